// File: core/nvs_pkg.sv
package nvs_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned PUR_NS = 200;
  localparam int unsigned PUR_CYC = (PUR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RECALL_NS = 2500;
  localparam int unsigned RECALL_CYC = (RECALL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STORE_NS = 10000000;
  localparam int unsigned STORE_CYC = STORE_NS / CLK_NS;
  localparam int unsigned TIMER_W = 18;
  localparam int unsigned PUR_W = 4;

  // ***************************************************
  // instruction format
  // ***************************************************
  localparam int unsigned OP_W = 3;
  localparam int unsigned SH_W = 7;
  localparam logic [2:0] LAST_CNT = 3'h6;
  localparam logic [OP_W-1:0] OP_LOCK = 3'h0;
  localparam logic [OP_W-1:0] OP_COMMIT = 3'h1;
  localparam logic [OP_W-1:0] OP_UNLOCK = 3'h4;
  localparam logic [OP_W-1:0] OP_RELOAD = 3'h5;

  // ***************************************************
  // pins: bit 0 store_n, bit 1 recall_n, bit 2 low supply
  // ***************************************************
  localparam int unsigned NPIN = 3;
  localparam int unsigned PIN_STORE = 0;
  localparam int unsigned PIN_RECALL = 1;
  localparam int unsigned PIN_LOW = 2;
  localparam logic [NPIN-1:0] PIN_RST = 3'h3;

  // ***************************************************
  // core states
  // ***************************************************
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h1,
    ST_IDLE = 4'h2,
    ST_RECALL = 4'h4,
    ST_STORE = 4'h8
  } nvs_state_t;

endpackage : nvs_pkg

// File: core/nvs_timer.sv
module nvs_timer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [nvs_pkg::TIMER_W-1:0] count_in,
  output logic done_out
);

  logic [nvs_pkg::TIMER_W-1:0] cnt_ff;
  logic [nvs_pkg::TIMER_W-1:0] nxt_cnt;
  logic nxt_done;

  // ***************************************************
  // down counter, one-cycle done when it runs out
  // ***************************************************
  assign nxt_cnt = load_in ? count_in :
                   (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign nxt_done = !load_in && (cnt_ff == {{(nvs_pkg::TIMER_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      done_out <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_out <= nxt_done;
    end
  end

endmodule : nvs_timer

// File: core/nvs_guard_top.sv
module nvs_guard_top #(
  parameter int unsigned STORE_CYCLES = nvs_pkg::STORE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sk_clk_in,
  input wire logic ce_in,
  input wire logic di_in,
  input wire logic store_n_in,
  input wire logic recall_n_in,
  input wire logic low_supply_in,
  output logic busy_out,
  output logic program_unlock_out,
  output logic prev_reload_out,
  output logic nv_reload_active_out,
  output logic nv_commit_active_out,
  output logic ram_write_allow_out,
  output logic ram_read_allow_out
);

  // ***************************************************
  // link domain declarations
  // ***************************************************
  logic lk_rst_s1_ff;
  logic lk_rst_s2_ff;
  logic lk_rst_s3_ff;
  logic lk_rst;
  logic lk_in_frame_ff;
  logic lk_done_ff;
  logic [2:0] lk_cnt_ff;
  logic [nvs_pkg::SH_W-1:0] lk_sh_ff;
  logic [nvs_pkg::OP_W-1:0] lk_cmd_ff;
  logic lk_req_ff;
  logic lk_ack_s1_ff;
  logic lk_ack_s2_ff;
  logic lk_ack_s3_ff;
  logic lk_start;
  logic lk_shift;
  logic lk_last;
  logic lk_free;
  logic lk_send;
  logic [nvs_pkg::OP_W-1:0] lk_opcode;

  // ***************************************************
  // core domain declarations
  // ***************************************************
  logic c_req_s1_ff;
  logic c_req_s2_ff;
  logic c_req_s3_ff;
  logic c_ack_ff;
  logic new_cmd;
  logic cmd_lock;
  logic cmd_unlock;
  logic cmd_commit;
  logic cmd_reload;
  logic [nvs_pkg::NPIN-1:0] pin_raw;
  logic [nvs_pkg::NPIN-1:0] pin_s1_ff;
  logic [nvs_pkg::NPIN-1:0] pin_s2_ff;
  logic [nvs_pkg::NPIN-1:0] pin_s3_ff;
  logic [nvs_pkg::NPIN-1:0] pin_lvl_ff;
  logic [nvs_pkg::NPIN-1:0] pin_old_ff;
  logic store_edge;
  logic recall_edge;
  logic low_supply;
  nvs_pkg::nvs_state_t state_ff;
  nvs_pkg::nvs_state_t nxt_state;
  logic [nvs_pkg::PUR_W-1:0] pur_cnt_ff;
  logic [nvs_pkg::PUR_W-1:0] nxt_pur_cnt;
  logic pur_done;
  logic idle;
  logic recall_req;
  logic store_req;
  logic tmr_load;
  logic [nvs_pkg::TIMER_W-1:0] tmr_count;
  logic tmr_done;
  logic recall_end;
  logic store_end;
  logic wel_ff;
  logic nxt_wel;
  logic prev_ff;
  logic nxt_prev;
  logic nxt_busy;
  logic nxt_reload_act;
  logic nxt_commit_act;
  logic nxt_read_allow;
  logic nxt_write_allow;

  // ***************************************************
  // link reset synchroniser
  // ***************************************************
  assign lk_rst = lk_rst_s2_ff && lk_rst_s3_ff;

  always_ff @(posedge sk_clk_in) begin
    lk_rst_s1_ff <= rst_in;
    lk_rst_s2_ff <= lk_rst_s1_ff;
    lk_rst_s3_ff <= lk_rst_s2_ff;
  end

  // ***************************************************
  // link instruction shifter
  // ***************************************************
  // start bit opens a frame, seven more bits close the instruction
  assign lk_start = ce_in && !lk_in_frame_ff && !lk_done_ff && di_in;
  assign lk_shift = ce_in && lk_in_frame_ff;
  assign lk_last = lk_shift && (lk_cnt_ff == nvs_pkg::LAST_CNT);
  assign lk_opcode = {lk_sh_ff[1:0], di_in};
  // a new instruction crosses only once the previous one was taken
  assign lk_free = (lk_req_ff == lk_ack_s3_ff) && (lk_ack_s2_ff == lk_ack_s3_ff);
  assign lk_send = lk_last && lk_free;

  always_ff @(posedge sk_clk_in) begin
    if (lk_rst || !ce_in) begin
      lk_in_frame_ff <= 1'b0;
      lk_done_ff <= 1'b0;
      lk_cnt_ff <= 3'h0;
    end else begin
      lk_in_frame_ff <= lk_start || (lk_in_frame_ff && !lk_last);
      lk_done_ff <= lk_done_ff || lk_last;
      lk_cnt_ff <= lk_shift ? lk_cnt_ff + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge sk_clk_in) begin
    if (lk_rst) begin
      lk_sh_ff <= '0;
      lk_cmd_ff <= nvs_pkg::OP_LOCK;
      lk_req_ff <= 1'b0;
    end else begin
      lk_sh_ff <= lk_shift ? {lk_sh_ff[nvs_pkg::SH_W-2:0], di_in} : lk_sh_ff;
      lk_cmd_ff <= lk_send ? lk_opcode : lk_cmd_ff;
      lk_req_ff <= lk_send ? !lk_req_ff : lk_req_ff;
    end
  end

  // ***************************************************
  // acknowledge back into the link domain
  // ***************************************************
  always_ff @(posedge sk_clk_in) begin
    if (lk_rst) begin
      lk_ack_s1_ff <= 1'b0;
      lk_ack_s2_ff <= 1'b0;
      lk_ack_s3_ff <= 1'b0;
    end else begin
      lk_ack_s1_ff <= c_ack_ff;
      lk_ack_s2_ff <= lk_ack_s1_ff;
      lk_ack_s3_ff <= lk_ack_s2_ff;
    end
  end

  // ***************************************************
  // request into the core domain
  // ***************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      c_req_s1_ff <= 1'b0;
      c_req_s2_ff <= 1'b0;
      c_req_s3_ff <= 1'b0;
      c_ack_ff <= 1'b0;
    end else begin
      c_req_s1_ff <= lk_req_ff;
      c_req_s2_ff <= c_req_s1_ff;
      c_req_s3_ff <= c_req_s2_ff;
      c_ack_ff <= new_cmd ? c_req_s3_ff : c_ack_ff;
    end
  end

  // ***************************************************
  // instruction decode
  // ***************************************************
  // the opcode register is held still until the acknowledge returns
  assign new_cmd = (c_req_s2_ff == c_req_s3_ff) && (c_req_s3_ff != c_ack_ff);
  // instructions that land while busy are taken and dropped
  assign cmd_lock = new_cmd && idle && (lk_cmd_ff == nvs_pkg::OP_LOCK);
  assign cmd_commit = new_cmd && idle && (lk_cmd_ff == nvs_pkg::OP_COMMIT);
  assign cmd_unlock = new_cmd && idle && (lk_cmd_ff == nvs_pkg::OP_UNLOCK);
  assign cmd_reload = new_cmd && idle && (lk_cmd_ff == nvs_pkg::OP_RELOAD);

  // ***************************************************
  // pin synchronisers and filters
  // ***************************************************
  assign pin_raw = {low_supply_in, recall_n_in, store_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < nvs_pkg::NPIN; gi = gi + 1) begin : g_pin
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          pin_s1_ff[gi] <= nvs_pkg::PIN_RST[gi];
          pin_s2_ff[gi] <= nvs_pkg::PIN_RST[gi];
          pin_s3_ff[gi] <= nvs_pkg::PIN_RST[gi];
          pin_lvl_ff[gi] <= nvs_pkg::PIN_RST[gi];
          pin_old_ff[gi] <= nvs_pkg::PIN_RST[gi];
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
          pin_lvl_ff[gi] <= (pin_s2_ff[gi] == pin_s3_ff[gi]) ? pin_s3_ff[gi] : pin_lvl_ff[gi];
          pin_old_ff[gi] <= pin_lvl_ff[gi];
        end
      end
    end
  endgenerate

  // one pulse per falling edge, so a held pin acts once
  assign store_edge = pin_old_ff[nvs_pkg::PIN_STORE] && !pin_lvl_ff[nvs_pkg::PIN_STORE];
  assign recall_edge = pin_old_ff[nvs_pkg::PIN_RECALL] && !pin_lvl_ff[nvs_pkg::PIN_RECALL];
  assign low_supply = pin_lvl_ff[nvs_pkg::PIN_LOW];

  // ***************************************************
  // transfer requests
  // ***************************************************
  assign idle = (state_ff == nvs_pkg::ST_IDLE);
  assign recall_req = idle && (cmd_reload || recall_edge);
  // commit needs both latches, a request and a good supply
  assign store_req = idle && !recall_req && (cmd_commit || store_edge)
                     && wel_ff && prev_ff && !low_supply;

  // ***************************************************
  // power-up inhibit counter
  // ***************************************************
  assign pur_done = (pur_cnt_ff == nvs_pkg::PUR_W'(nvs_pkg::PUR_CYC - 1));
  assign nxt_pur_cnt = pur_done ? pur_cnt_ff : pur_cnt_ff + 1'b1;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pur_cnt_ff <= '0;
    end else begin
      pur_cnt_ff <= nxt_pur_cnt;
    end
  end

  // ***************************************************
  // transfer timer
  // ***************************************************
  assign recall_end = (state_ff == nvs_pkg::ST_RECALL) && tmr_done;
  assign store_end = (state_ff == nvs_pkg::ST_STORE) && tmr_done;
  assign tmr_load = recall_req || store_req
                    || ((state_ff == nvs_pkg::ST_POWERUP) && pur_done);
  assign tmr_count = store_req ? nvs_pkg::TIMER_W'(STORE_CYCLES)
                               : nvs_pkg::TIMER_W'(nvs_pkg::RECALL_CYC);

  nvs_timer u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .done_out(tmr_done)
  );

  // ***************************************************
  // state machine
  // ***************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      nvs_pkg::ST_POWERUP: begin
        // after the inhibit time the array is reloaded unasked
        if (pur_done) begin
          nxt_state = nvs_pkg::ST_RECALL;
        end
      end
      nvs_pkg::ST_IDLE: begin
        if (recall_req) begin
          nxt_state = nvs_pkg::ST_RECALL;
        end else if (store_req) begin
          nxt_state = nvs_pkg::ST_STORE;
        end
      end
      nvs_pkg::ST_RECALL: begin
        if (tmr_done) begin
          nxt_state = nvs_pkg::ST_IDLE;
        end
      end
      nvs_pkg::ST_STORE: begin
        if (tmr_done) begin
          nxt_state = nvs_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = nvs_pkg::ST_POWERUP;
      end
    endcase
  end

  // ***************************************************
  // unlock and previous-reload latches
  // ***************************************************
  // clearing causes win over unlock; low supply clears at once
  assign nxt_wel = (low_supply || store_end || cmd_lock) ? 1'b0
                   : (cmd_unlock ? 1'b1 : wel_ff);
  assign nxt_prev = prev_ff || recall_end;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wel_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      wel_ff <= nxt_wel;
      prev_ff <= nxt_prev;
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_ff <= nvs_pkg::ST_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ***************************************************
  // next output values
  // ***************************************************
  assign nxt_busy = (nxt_state != nvs_pkg::ST_IDLE);
  assign nxt_reload_act = (nxt_state == nvs_pkg::ST_RECALL);
  assign nxt_commit_act = (nxt_state == nvs_pkg::ST_STORE);
  assign nxt_read_allow = (nxt_state == nvs_pkg::ST_IDLE);
  assign nxt_write_allow = nxt_read_allow && nxt_wel && nxt_prev;

  // ***************************************************
  // registered outputs
  // ***************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_out <= 1'b1;
      program_unlock_out <= 1'b0;
      prev_reload_out <= 1'b0;
      nv_reload_active_out <= 1'b0;
      nv_commit_active_out <= 1'b0;
      ram_write_allow_out <= 1'b0;
      ram_read_allow_out <= 1'b0;
    end else begin
      busy_out <= nxt_busy;
      program_unlock_out <= nxt_wel;
      prev_reload_out <= nxt_prev;
      nv_reload_active_out <= nxt_reload_act;
      nv_commit_active_out <= nxt_commit_act;
      ram_write_allow_out <= nxt_write_allow;
      ram_read_allow_out <= nxt_read_allow;
    end
  end

endmodule : nvs_guard_top

// File: sim/nvs_host.sv
module nvs_host (
  output logic sk_clk_out,
  output logic ce_out,
  output logic di_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sk_clk_out = 1'b0;
    ce_out = 1'b0;
    di_out = 1'b0;
  end

  // link clock runs only inside a frame, for two edges after it, or in a reset burst
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      #3 sk_clk_out = 1'b1;
      #3 sk_clk_out = 1'b0;
    end
  endtask : pulse

  // nbits below 8 cuts the frame short
  task automatic send(input logic [3:0] addr, input logic [2:0] op, input int nbits);
    logic [7:0] frame;
    frame = {1'b1, addr, op};
    ce_out = 1'b1;
    for (int i = 7; i > 7 - nbits; i--) begin
      di_out = frame[i];
      pulse(1);
    end
    ce_out = 1'b0;
    di_out = ~di_out;
    pulse(2);
  endtask : send
endmodule : nvs_host

// File: sim/nvs_guard_sva.sv
module nvs_guard_sva #(
  parameter int unsigned STORE_CYCLES = 20
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sk_clk_in,
  input wire logic ce_in,
  input wire logic di_in,
  input wire logic store_n_in,
  input wire logic recall_n_in,
  input wire logic low_supply_in,
  input wire logic busy_out,
  input wire logic program_unlock_out,
  input wire logic prev_reload_out,
  input wire logic nv_reload_active_out,
  input wire logic nv_commit_active_out,
  input wire logic ram_write_allow_out,
  input wire logic ram_read_allow_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  int unsigned xfer_len_ff;

  // ***************************************************
  // transfer length counter
  // ***************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in || !(nv_commit_active_out || nv_reload_active_out)) begin
      xfer_len_ff <= 0;
    end else begin
      xfer_len_ff <= xfer_len_ff + 1;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  a_powerup_locked: assert property ($fell(rst_in) |->
    (busy_out && !program_unlock_out && !ram_write_allow_out) [*8])
    else $error("unlock or idle seen during power-up");
  a_commit_needs_latches: assert property ($rose(nv_commit_active_out) |->
    $past(program_unlock_out) && prev_reload_out)
    else $error("commit started without both latches");
  a_commit_end_locks: assert property ($fell(nv_commit_active_out) |->
    ##[0:1] !program_unlock_out) else $error("unlock kept after commit");
  a_commit_inhibits: assert property (nv_commit_active_out [*2] |-> busy_out &&
    !nv_reload_active_out && !ram_read_allow_out && !ram_write_allow_out)
    else $error("other function active during commit");
  a_commit_length: assert property ($fell(nv_commit_active_out) |->
    xfer_len_ff + 1 >= STORE_CYCLES && xfer_len_ff <= STORE_CYCLES + 1)
    else $error("commit length wrong");
  a_reload_length: assert property ($fell(nv_reload_active_out) |->
    xfer_len_ff + 1 >= nvs_pkg::RECALL_CYC && xfer_len_ff <= nvs_pkg::RECALL_CYC + 1)
    else $error("reload length wrong");
  a_reload_sets_prev: assert property ($fell(nv_reload_active_out) |->
    ##[0:1] prev_reload_out) else $error("reload left prev latch clear");
  a_low_clears_unlock: assert property (low_supply_in [*8] |->
    !program_unlock_out) else $error("unlock set under low supply");
  a_write_needs_unlock: assert property (ram_write_allow_out |-> prev_reload_out &&
    (program_unlock_out || $past(program_unlock_out))) else $error("write allowed while locked");
  a_read_when_idle: assert property ($stable(busy_out) |->
    ram_read_allow_out == !busy_out) else $error("read allow disagrees with busy");

  c_commit: cover property ($rose(nv_commit_active_out));
  c_reload: cover property ($fell(nv_reload_active_out));
  c_low: cover property (low_supply_in [*8]);
endmodule : nvs_guard_sva

bind nvs_guard_top nvs_guard_sva #(.STORE_CYCLES(STORE_CYCLES)) chk_u (
  .clock_in(clock_in), .rst_in(rst_in), .sk_clk_in(sk_clk_in), .ce_in(ce_in),
  .di_in(di_in), .store_n_in(store_n_in), .recall_n_in(recall_n_in),
  .low_supply_in(low_supply_in), .busy_out(busy_out), .program_unlock_out(program_unlock_out),
  .prev_reload_out(prev_reload_out), .nv_reload_active_out(nv_reload_active_out),
  .nv_commit_active_out(nv_commit_active_out), .ram_write_allow_out(ram_write_allow_out),
  .ram_read_allow_out(ram_read_allow_out)
);

// File: sim/nvs_guard_top_tb.sv
module nvs_guard_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int I_BUSY = 6;
  localparam int I_UNLOCK = 5;
  localparam int I_RELOAD = 3;
  localparam int I_COMMIT = 2;
  logic clock_in, rst_in, store_n, recall_n, low_supply;
  logic sk_clk, ce, di, busy, unlock, prev, reload, commit, wr_ok, rd_ok;
  logic [6:0] outs;
  int fail_count, checks;
  assign outs = {busy, unlock, prev, reload, commit, wr_ok, rd_ok};

  nvs_host host_u (.sk_clk_out(sk_clk), .ce_out(ce), .di_out(di));
  nvs_guard_top #(.STORE_CYCLES(20)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .sk_clk_in(sk_clk), .ce_in(ce), .di_in(di),
    .store_n_in(store_n), .recall_n_in(recall_n), .low_supply_in(low_supply),
    .busy_out(busy), .program_unlock_out(unlock), .prev_reload_out(prev),
    .nv_reload_active_out(reload), .nv_commit_active_out(commit),
    .ram_write_allow_out(wr_ok), .ram_read_allow_out(rd_ok)
  );

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cycles

  task automatic wait_out(input int idx, input logic val, input int bound);
    int n;
    n = 0;
    while (outs[idx] !== val && n < bound) begin
      cycles(1);
      n++;
    end
    checks++;
    if (outs[idx] !== val) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, outs[idx], val);
      conclude();
    end
  endtask : wait_out

  task automatic cmd(input logic [2:0] op, input int nbits);
    host_u.send(4'ha, op, nbits);
    cycles(12);
  endtask : cmd

  task automatic pin(input int which, input logic v);
    @(posedge clock_in);
    #1;
    case (which)
      0: store_n = v;
      1: recall_n = v;
      default: low_supply = v;
    endcase
  endtask : pin

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_lock_cycle();
    cmd(nvs_pkg::OP_UNLOCK, 8);
    check(unlock, 1'b1);
    check(wr_ok, 1'b1);
    cmd(3'h6, 8);
    check(unlock, 1'b1);
    cmd(nvs_pkg::OP_LOCK, 8);
    check(unlock, 1'b0);
    check(wr_ok, 1'b0);
    check(rd_ok, 1'b1);
    $display("test lock_cycle done");
  endtask : t_lock_cycle

  task automatic t_refused();
    cmd(nvs_pkg::OP_COMMIT, 8);
    check(commit, 1'b0);
    pin(0, 1'b0);
    cycles(10);
    check(commit, 1'b0);
    pin(0, 1'b1);
    $display("test refused done");
  endtask : t_refused

  task automatic t_soft_commit();
    cmd(nvs_pkg::OP_UNLOCK, 8);
    cmd(nvs_pkg::OP_COMMIT, 8);
    wait_out(I_COMMIT, 1'b1, 10);
    check(busy, 1'b1);
    wait_out(I_COMMIT, 1'b0, 40);
    check(unlock, 1'b0);
    $display("test soft_commit done");
  endtask : t_soft_commit

  task automatic t_pin_commit();
    cmd(nvs_pkg::OP_UNLOCK, 8);
    pin(0, 1'b0);
    wait_out(I_COMMIT, 1'b1, 12);
    pin(1, 1'b0);
    cmd(nvs_pkg::OP_UNLOCK, 8);
    pin(1, 1'b1);
    wait_out(I_COMMIT, 1'b0, 40);
    check(unlock, 1'b0);
    cycles(10);
    check(reload, 1'b0);
    check(commit, 1'b0);
    cmd(nvs_pkg::OP_UNLOCK, 8);
    check(unlock, 1'b1);
    check(commit, 1'b0);
    pin(0, 1'b1);
    $display("test pin_commit done");
  endtask : t_pin_commit

  task automatic t_reload();
    cmd(nvs_pkg::OP_RELOAD, 8);
    wait_out(I_RELOAD, 1'b1, 5);
    check(busy, 1'b1);
    wait_out(I_RELOAD, 1'b0, 60);
    check(prev, 1'b1);
    pin(1, 1'b0);
    wait_out(I_RELOAD, 1'b1, 12);
    wait_out(I_RELOAD, 1'b0, 60);
    cycles(10);
    check(reload, 1'b0);
    pin(1, 1'b1);
    $display("test reload done");
  endtask : t_reload

  task automatic t_low_supply();
    cmd(nvs_pkg::OP_UNLOCK, 8);
    pin(2, 1'b1);
    cycles(8);
    check(unlock, 1'b0);
    cmd(nvs_pkg::OP_UNLOCK, 8);
    check(unlock, 1'b0);
    cmd(nvs_pkg::OP_COMMIT, 8);
    check(commit, 1'b0);
    pin(2, 1'b0);
    $display("test low_supply done");
  endtask : t_low_supply

  task automatic t_abort();
    cmd(nvs_pkg::OP_UNLOCK, 4);
    check(unlock, 1'b0);
    cmd(nvs_pkg::OP_UNLOCK, 8);
    check(unlock, 1'b1);
    cmd(nvs_pkg::OP_LOCK, 8);
    $display("test abort done");
  endtask : t_abort

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  initial begin
    rst_in = 1'b1;
    store_n = 1'b1;
    recall_n = 1'b1;
    low_supply = 1'b0;
    fail_count = 0;
    checks = 0;
    host_u.pulse(5);
    cycles(4);
    check(busy, 1'b1);
    check(unlock, 1'b0);
    rst_in = 1'b0;
    // link reset synchroniser needs edges to let go
    host_u.pulse(3);
    cycles(4);
    check(busy, 1'b1);
    wait_out(I_BUSY, 1'b0, 80);
    check(prev, 1'b1);
    check(wr_ok, 1'b0);
    $display("test powerup done");
    t_lock_cycle();
    t_refused();
    t_soft_commit();
    t_pin_commit();
    t_reload();
    t_low_supply();
    t_abort();
    conclude();
  end
endmodule : nvs_guard_top_tb
